/* File: logic/pdsm_pkg.sv */
// package: register map, field layout, reset values and codes for prescaler decode and status mux
`default_nettype none
package pdsm_pkg;

  // ==========================================================
  // register map
  localparam logic [9:0] PDSM_ADDR_PRESC       = 10'h016;
  localparam logic [9:0] PDSM_ADDR_STATUS_SEL  = 10'h017;
  localparam logic [9:0] PDSM_ADDR_SEL_LOCK    = 10'h01d;

  localparam logic [7:0] PDSM_RST_PRESC        = 8'h06;
  localparam logic [7:0] PDSM_RST_STATUS_SEL   = 8'h00;
  localparam logic [7:0] PDSM_RST_SEL_LOCK     = 8'h00;
  localparam logic [7:0] PDSM_READ_UNMAPPED    = 8'h00;

  // ==========================================================
  // field positions
  localparam int PDSM_PRESC_LSB   = 0;
  localparam int PDSM_PRESC_MSB   = 2;
  localparam int PDSM_SEL_LSB     = 2;
  localparam int PDSM_SEL_MSB     = 7;
  localparam int PDSM_LOCK_BIT    = 7;
  localparam int PDSM_SYNC_STAGES = 3;
  localparam int PDSM_NUM_PINS    = 3;

  // ==========================================================
  // prescaler codes
  typedef enum logic [2:0] {
    PRESC_FD1  = 3'b000,
    PRESC_FD2  = 3'b001,
    PRESC_DM2  = 3'b010,
    PRESC_DM4  = 3'b011,
    PRESC_DM8  = 3'b100,
    PRESC_FD16 = 3'b101,
    PRESC_DM32 = 3'b110,
    PRESC_FD3  = 3'b111
  } pdsm_presc_code_t;

  localparam logic [5:0] PDSM_RATIO_1  = 6'h01;
  localparam logic [5:0] PDSM_RATIO_2  = 6'h02;
  localparam logic [5:0] PDSM_RATIO_3  = 6'h03;
  localparam logic [5:0] PDSM_RATIO_4  = 6'h04;
  localparam logic [5:0] PDSM_RATIO_8  = 6'h08;
  localparam logic [5:0] PDSM_RATIO_16 = 6'h10;
  localparam logic [5:0] PDSM_RATIO_32 = 6'h20;
  localparam logic [5:0] PDSM_ONE      = 6'h01;
  localparam logic [5:0] PDSM_ZERO6    = 6'h00;

  // ==========================================================
  // status selection codes
  localparam logic [5:0] SEL_GND      = 6'h00;
  localparam logic [5:0] SEL_NDIV     = 6'h01;
  localparam logic [5:0] SEL_RDIV     = 6'h02;
  localparam logic [5:0] SEL_SWALLOW  = 6'h03;
  localparam logic [5:0] SEL_PRESC    = 6'h04;
  localparam logic [5:0] SEL_PFD_UP   = 6'h05;
  localparam logic [5:0] SEL_PFD_DN   = 6'h06;
  localparam logic [5:0] SEL_REF_GND  = 6'h20;
  localparam logic [5:0] SEL_FIRST_REF_INPUT     = 6'h21;
  localparam logic [5:0] SEL_SECOND_REF_INPUT     = 6'h22;
  localparam logic [5:0] SEL_REF_ACT  = 6'h23;
  localparam logic [5:0] SEL_REF_IDLE = 6'h24;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic feedback_div;
    logic reference_div;
    logic swallow_out;
    logic pfd_up;
    logic pfd_down;
  } pdsm_taps_t;

  typedef struct packed {
    logic [5:0] ratio;
    logic       dual_modulus_mode;
  } pdsm_ratio_t;

endpackage : pdsm_pkg
`default_nettype wire

/* File: logic/pdsm_top.sv */
// module: feedback prescaler decode and divide, status pin selector, register slice
//
// What this block does
// - the prescaler mode is the three-bit field in bits [2:0] of register 0x016.
// - code 010 divides by two or three while the swallow count is nonzero, else by two.
// - code 011 divides by four or five while the swallow count is nonzero, else by four.
// - code 100 divides by eight or nine while the swallow count is nonzero, else by eight.
// - code 110, the reset value, divides by thirty-two or thirty-three, else by thirty-two.
// - an undefined selection with top bit zero, the all-zero one included, drives the pin low.
// - selection 000001 routes the delayed feedback divider output.
// - selection 000010 routes the delayed reference divider output.
// - with the top bit one the reference monitor table applies and 100000 drives the pin low.
// - selection 100001 routes the first reference, or the differential reference in differential mode.
// - selection 100010 routes the second reference and is ground in differential mode.
// - selection 100011 routes the reference that currently feeds the loop.
// - selection 100100 routes the reference not feeding the loop and is ground in differential mode.
`timescale 1ns/100ps
`default_nettype none
module pdsm_top
  import pdsm_pkg::*;
(
  // clock, reset, enable
  input  wire  logic        clk,
  input  wire  logic        rst_n,
  input  wire  logic        ce,
  // register map port
  input  wire  logic        reg_wr_en,
  input  wire  logic        reg_rd_en,
  input  wire  logic [9:0]  reg_addr,
  input  wire  logic [7:0]  reg_wdata,
  output var   logic [7:0]  reg_rdata,
  output var   logic        reg_rd_valid,
  // feedback path
  input  wire  logic [5:0]  swallow_value,
  input  wire  logic        modulus_high,
  output var   logic        presc_out,
  output var   logic [5:0]  presc_ratio,
  output var   logic        presc_dual,
  // internal taps
  input  wire  pdsm_taps_t  taps,
  // reference pins and state
  input  wire  logic        first_ref_input,
  input  wire  logic        second_ref_input,
  input  wire  logic        diff_ref_input,
  input  wire  logic        ref_diff_mode,
  input  wire  logic        ref_second_active,
  // status pin
  output var   logic        status_pin
);

  // ==========================================================
  // decoding
  function automatic pdsm_ratio_t decode_presc(input logic [2:0] code);
    pdsm_ratio_t r;
    r.dual_modulus_mode = 1'b0;
    r.ratio             = PDSM_RATIO_1;
    case (pdsm_presc_code_t'(code))
      PRESC_FD1: begin
        r.ratio = PDSM_RATIO_1;
      end
      PRESC_FD2: begin
        r.ratio = PDSM_RATIO_2;
      end
      PRESC_DM2: begin
        r.ratio             = PDSM_RATIO_2;
        r.dual_modulus_mode = 1'b1;
      end
      PRESC_DM4: begin
        r.ratio             = PDSM_RATIO_4;
        r.dual_modulus_mode = 1'b1;
      end
      PRESC_DM8: begin
        r.ratio             = PDSM_RATIO_8;
        r.dual_modulus_mode = 1'b1;
      end
      PRESC_FD16: begin
        r.ratio = PDSM_RATIO_16;
      end
      PRESC_DM32: begin
        r.ratio             = PDSM_RATIO_32;
        r.dual_modulus_mode = 1'b1;
      end
      PRESC_FD3: begin
        r.ratio = PDSM_RATIO_3;
      end
      default: begin
        r.ratio = PDSM_RATIO_1;
      end
    endcase
    return r;
  endfunction : decode_presc

  // ==========================================================
  // registers
  logic [7:0]  presc_reg;
  logic [7:0]  status_sel_reg;
  logic [7:0]  sel_lock_reg;
  logic        wr_presc;
  logic        wr_status;
  logic        wr_lock;

  assign wr_presc  = ce && reg_wr_en && (reg_addr == PDSM_ADDR_PRESC);
  assign wr_status = ce && reg_wr_en && (reg_addr == PDSM_ADDR_STATUS_SEL);
  assign wr_lock   = ce && reg_wr_en && (reg_addr == PDSM_ADDR_SEL_LOCK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= PDSM_RST_PRESC;
    end else if (wr_presc) begin
      presc_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_lock_reg <= PDSM_RST_SEL_LOCK;
    end else if (wr_lock) begin
      sel_lock_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_sel_reg <= PDSM_RST_STATUS_SEL;
    end else if (wr_status) begin
      // low bits are stored only; the selection field obeys the lock
      status_sel_reg[PDSM_SEL_LSB-1:0] <= reg_wdata[PDSM_SEL_LSB-1:0];
      if (!sel_lock_reg[PDSM_LOCK_BIT]) begin
        status_sel_reg[PDSM_SEL_MSB:PDSM_SEL_LSB] <= reg_wdata[PDSM_SEL_MSB:PDSM_SEL_LSB];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= PDSM_READ_UNMAPPED;
      reg_rd_valid <= 1'b0;
    end else if (ce) begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        case (reg_addr)
          PDSM_ADDR_PRESC: begin
            reg_rdata <= presc_reg;
          end
          PDSM_ADDR_STATUS_SEL: begin
            reg_rdata <= status_sel_reg;
          end
          PDSM_ADDR_SEL_LOCK: begin
            reg_rdata <= sel_lock_reg;
          end
          default: begin
            reg_rdata <= PDSM_READ_UNMAPPED;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // prescaler
  pdsm_ratio_t cur_ratio;
  logic [5:0]  modulus;
  logic [5:0]  presc_cnt;
  logic [5:0]  next_presc_cnt;
  logic        use_extra;

  assign cur_ratio = decode_presc(presc_reg[PDSM_PRESC_MSB:PDSM_PRESC_LSB]);
  // the extra count only exists in dual modulus mode with a nonzero swallow count
  assign use_extra = cur_ratio.dual_modulus_mode && (swallow_value != PDSM_ZERO6)
                     && modulus_high;
  assign modulus   = use_extra ? 6'(cur_ratio.ratio + PDSM_ONE) : cur_ratio.ratio;

  // a smaller modulus taking effect mid-count wraps at once
  always_comb begin
    if (presc_cnt >= 6'(modulus - PDSM_ONE)) begin
      next_presc_cnt = PDSM_ZERO6;
    end else begin
      next_presc_cnt = 6'(presc_cnt + PDSM_ONE);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt <= PDSM_ZERO6;
      presc_out <= 1'b0;
    end else if (ce) begin
      presc_cnt <= next_presc_cnt;
      presc_out <= (next_presc_cnt == PDSM_ZERO6);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ratio <= PDSM_RATIO_32;
      presc_dual  <= 1'b1;
    end else if (ce) begin
      presc_ratio <= modulus;
      presc_dual  <= cur_ratio.dual_modulus_mode;
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [PDSM_NUM_PINS-1:0] pin_raw;
  logic [PDSM_NUM_PINS-1:0] pin_clean;

  assign pin_raw = {diff_ref_input, second_ref_input, first_ref_input};

  genvar gi;
  generate
    for (gi = 0; gi < PDSM_NUM_PINS; gi++) begin : g_sync
      logic [PDSM_SYNC_STAGES-1:0] sh;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sh <= '0;
        end else if (ce) begin
          sh <= {sh[PDSM_SYNC_STAGES-2:0], pin_raw[gi]};
        end
      end
      // a pin change is taken once the last two stages agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_clean[gi] <= 1'b0;
        end else if (ce && (sh[PDSM_SYNC_STAGES-2] == sh[PDSM_SYNC_STAGES-1])) begin
          pin_clean[gi] <= sh[PDSM_SYNC_STAGES-1];
        end
      end
    end
  endgenerate

  // ==========================================================
  // status selector
  logic [5:0] sel;
  logic       first_ref_input_q;
  logic       second_ref_input_q;
  logic       refd_q;
  logic       next_status;

  assign sel    = status_sel_reg[PDSM_SEL_MSB:PDSM_SEL_LSB];
  assign first_ref_input_q = pin_clean[0];
  assign second_ref_input_q = pin_clean[1];
  assign refd_q = pin_clean[2];

  always_comb begin
    case (sel)
      SEL_NDIV: begin
        next_status = taps.feedback_div;
      end
      SEL_RDIV: begin
        next_status = taps.reference_div;
      end
      SEL_SWALLOW: begin
        next_status = taps.swallow_out;
      end
      SEL_PRESC: begin
        next_status = presc_out;
      end
      SEL_PFD_UP: begin
        next_status = taps.pfd_up;
      end
      SEL_PFD_DN: begin
        next_status = taps.pfd_down;
      end
      SEL_REF_GND: begin
        next_status = 1'b0;
      end
      SEL_FIRST_REF_INPUT: begin
        next_status = ref_diff_mode ? refd_q : first_ref_input_q;
      end
      SEL_SECOND_REF_INPUT: begin
        next_status = ref_diff_mode ? 1'b0 : second_ref_input_q;
      end
      SEL_REF_ACT: begin
        if (ref_diff_mode) begin
          next_status = refd_q;
        end else begin
          next_status = ref_second_active ? second_ref_input_q : first_ref_input_q;
        end
      end
      SEL_REF_IDLE: begin
        if (ref_diff_mode) begin
          next_status = 1'b0;
        end else begin
          next_status = ref_second_active ? first_ref_input_q : second_ref_input_q;
        end
      end
      default: begin
        next_status = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_pin <= 1'b0;
    end else if (ce) begin
      status_pin <= next_status;
    end
  end

endmodule : pdsm_top
`default_nettype wire

/* File: sim/pdsm_properties.sv */
// checker: properties of prescaler decode and status mux
`timescale 1ns/100ps
`default_nettype none
module pdsm_properties
  import pdsm_pkg::*;
(
  // clock and control
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  // register port
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rd_valid,
  // divider and pin
  input wire logic [5:0] swallow_value,
  input wire logic       modulus_high,
  input wire logic [5:0] presc_ratio,
  input wire logic       presc_dual,
  input wire pdsm_taps_t taps,
  input wire logic       ref_diff_mode,
  input wire logic       status_pin
);
  // ==========================================================
  // shadow registers
  logic [7:0] pq, sq, lq, rd_now;
  logic [5:0] sel, base;
  logic       dual_now, tap_now, tap_def, gnd_now;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pq <= PDSM_RST_PRESC;
      sq <= PDSM_RST_STATUS_SEL;
      lq <= PDSM_RST_SEL_LOCK;
    end else if (ce && reg_wr_en) begin
      if (reg_addr == PDSM_ADDR_PRESC) pq <= reg_wdata;
      if (reg_addr == PDSM_ADDR_STATUS_SEL) sq <= lq[7] ? {sq[7:2], reg_wdata[1:0]} : reg_wdata;
      if (reg_addr == PDSM_ADDR_SEL_LOCK) lq <= reg_wdata;
    end
  end
  always_comb begin
    sel = sq[7:2];
    dual_now = pq[2:0] inside {3'h2, 3'h3, 3'h4, 3'h6};
    base = (pq[2:0] == 3'h7) ? 6'h03 : (pq[2:0] == 3'h0) ? 6'h01 :
           (pq[2:0] == 3'h1) ? 6'h02 : 6'h01 << (pq[2:0] - 3'h1);
    rd_now = (reg_addr == PDSM_ADDR_PRESC) ? pq : (reg_addr == PDSM_ADDR_STATUS_SEL) ? sq :
             (reg_addr == PDSM_ADDR_SEL_LOCK) ? lq : PDSM_READ_UNMAPPED;
    gnd_now = (sel == SEL_REF_GND) || (!sel[5] && sel > SEL_PFD_DN) || (sel == SEL_GND);
    tap_def = sel inside {SEL_NDIV, SEL_RDIV, SEL_SWALLOW, SEL_PFD_UP, SEL_PFD_DN};
    tap_now = (sel == SEL_NDIV) ? taps.feedback_div : (sel == SEL_RDIV) ? taps.reference_div :
              (sel == SEL_SWALLOW) ? taps.swallow_out : (sel == SEL_PFD_UP) ? taps.pfd_up : taps.pfd_down;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_valid; ce && reg_rd_en |=> reg_rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
  property p_rd_pulse; ce && !reg_rd_en |=> !reg_rd_valid; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid without strobe");
  property p_rd_data; ce && reg_rd_en |=> reg_rdata == $past(rd_now); endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
  property p_dual; ce |=> presc_dual == $past(dual_now); endproperty
  a_dual: assert property (p_dual) else $error("dual flag wrong");
  property p_ratio; ce |=> presc_ratio == $past(base + 6'(dual_now && swallow_value != 6'h00 && modulus_high));
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_gnd; ce && gnd_now |=> !status_pin; endproperty
  a_gnd: assert property (p_gnd) else $error("pin not grounded");
  property p_tap; ce && tap_def |=> status_pin == $past(tap_now); endproperty
  a_tap: assert property (p_tap) else $error("tap routing wrong");
  property p_ref_na; ce && ref_diff_mode && (sel == SEL_SECOND_REF_INPUT || sel == SEL_REF_IDLE) |=> !status_pin; endproperty
  a_ref_na: assert property (p_ref_na) else $error("unavailable ref not low");
endmodule : pdsm_properties
bind pdsm_top pdsm_properties u_props (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .swallow_value(swallow_value), .modulus_high(modulus_high),
  .presc_ratio(presc_ratio), .presc_dual(presc_dual), .taps(taps), .ref_diff_mode(ref_diff_mode),
  .status_pin(status_pin));
`default_nettype wire

/* File: sim/tb_prescaler_decode_and_status_mux.sv */
// testbench: prescaler decode and status mux
`timescale 1ns/100ps
`default_nettype none
module tb_prescaler_decode_and_status_mux;
  import pdsm_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0, ce = 1'h1, wr = 1'h0, rd = 1'h0, mh = 1'h0, rv, po, du, pin;
  logic        r1 = 1'h0, r2 = 1'h0, rdf = 1'h0, dm = 1'h0, act = 1'h0, pp = 1'h0, po_q = 1'h0;
  logic [9:0]  addr = 10'h000;
  logic [7:0]  wd = 8'h00, rdt;
  logic [5:0]  sw = 6'h00, ra, s, e;
  pdsm_taps_t  taps = 5'h00, prev;
  logic [31:0] seed = 32'hc72e3bd2;
  int          miscompares = 0, checked = 0, n, m_presc = 6, m_sel = 0, m_lock = 0;
  always #20 clk = ~clk;
  pdsm_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(rdt), .reg_rd_valid(rv), .swallow_value(sw), .modulus_high(mh),
    .presc_out(po), .presc_ratio(ra), .presc_dual(du), .taps(taps), .first_ref_input(r1),
    .second_ref_input(r2), .diff_ref_input(rdf), .ref_diff_mode(dm), .ref_second_active(act),
    .status_pin(pin));
  // ==========================================================
  // models and tasks
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic exp_pin(input logic [5:0] c, input pdsm_taps_t t);
    case (c)
      SEL_NDIV: return t.feedback_div;
      SEL_RDIV: return t.reference_div;
      SEL_SWALLOW: return t.swallow_out;
      SEL_PRESC: return pp;
      SEL_PFD_UP: return t.pfd_up;
      SEL_PFD_DN: return t.pfd_down;
      SEL_FIRST_REF_INPUT: return dm ? rdf : r1;
      SEL_SECOND_REF_INPUT: return !dm && r2;
      SEL_REF_ACT: return dm ? rdf : (act ? r2 : r1);
      SEL_REF_IDLE: return !dm && (act ? r1 : r2);
      default: return 1'h0;
    endcase
  endfunction : exp_pin
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [9:0] a, input int d);
    @(negedge clk);
    {wr, addr, wd} = {1'h1, a, 8'(d)};
    @(negedge clk);
    wr = 1'h0;
    if (ce && a == PDSM_ADDR_PRESC) m_presc = d;
    if (ce && a == PDSM_ADDR_STATUS_SEL) m_sel = m_lock[7] ? (m_sel & 'hfc) | (d & 3) : d;
    if (ce && a == PDSM_ADDR_SEL_LOCK) m_lock = d;
  endtask : wreg
  task automatic rreg(input logic [9:0] a, input int exp);
    @(negedge clk);
    {rd, addr} = {1'h1, a};
    @(negedge clk);
    rd = 1'h0;
    chk({7'h00, rv}, 8'h01);
    chk(rdt, 8'(exp));
  endtask : rreg
  task automatic close_out();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // ==========================================================
  // scenarios
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'h1;
    rreg(PDSM_ADDR_PRESC, 6);
    rreg(PDSM_ADDR_SEL_LOCK, 0);
    rreg(10'h100, 0);
    chk({2'h0, ra}, 8'h20);
    for (int c = 0; c < 24; c++) begin
      wreg(PDSM_ADDR_PRESC, (c / 3) | (rnd() & 'hf8));
      {sw, mh} = {(c % 3 == 2) ? 6'(rnd() | 1) : 6'h00, 1'(c % 3 != 1)};
      e = (c / 3 == 7) ? 6'h03 : (c < 3) ? 6'h01 : (c / 3 == 1) ? 6'h02 : 6'h01 << (c / 3 - 1);
      e = 6'(e + (c / 3 inside {2, 3, 4, 6} && mh && sw != 0));
      repeat (2) @(negedge clk);
      chk({2'h0, ra}, {2'h0, e});
      chk({7'h00, du}, 8'(c / 3 inside {2, 3, 4, 6}));
      for (n = 0; n < 80 && po !== 1'h1; n++) @(negedge clk);
      n = 0;
      do begin @(negedge clk); n++; end while (po !== 1'h1 && n < 80);
      chk(8'(n), {2'h0, e});
      rreg(PDSM_ADDR_PRESC, m_presc);
    end
    for (int i = 0; i < 40; i++) begin
      s = (i < 8) ? 6'(i) : (i < 20) ? 6'(rnd() & 'h1f) : 6'(32 + i % 5);
      {r1, r2, rdf, dm, act} = {3'(rnd()), 1'(i / 5 % 2), 1'(i / 10 % 2)};
      wreg(PDSM_ADDR_STATUS_SEL, {s, 2'(rnd())});
      repeat (8) begin
        @(negedge clk);
        {prev, pp, po_q, taps} = {taps, po_q, po, 5'(rnd())};
      end
      if (s[5]) chk({7'h00, pin}, {7'h00, exp_pin(s, prev)});
      else chk({7'h00, pin}, {7'h00, exp_pin(s, prev)});
    end
    wreg(PDSM_ADDR_SEL_LOCK, 'h80);
    wreg(PDSM_ADDR_STATUS_SEL, 'h0b);
    rreg(PDSM_ADDR_STATUS_SEL, m_sel);
    wreg(PDSM_ADDR_SEL_LOCK, 0);
    ce = 1'h0;
    wreg(PDSM_ADDR_STATUS_SEL, 'h14);
    ce = 1'h1;
    wreg(PDSM_ADDR_STATUS_SEL, 'h09);
    rreg(PDSM_ADDR_STATUS_SEL, m_sel);
    close_out();
  end
  initial begin
    #(40 * 20000);
    miscompares++;
    close_out();
  end
endmodule : tb_prescaler_decode_and_status_mux
`default_nettype wire
